/* design/acsc_pkg.sv */
// Purpose: shared constants and types for the conversion start control
// Assumes: 20 MHz system clock, 10-bit converter result
// Notes:   control bit positions follow the converter control byte
package acsc_pkg;

    // ------------------------------------------------------------
    // control byte layout
    // ------------------------------------------------------------
    localparam int unsigned BUSY_BIT    = 4;
    localparam int unsigned TRIG_MSB    = 3;
    localparam int unsigned TRIG_LSB    = 2;
    localparam int unsigned WINDOW_BIT  = 1;
    localparam int unsigned JUSTIFY_BIT = 0;
    localparam int unsigned RESULT_W    = 10;
    localparam int unsigned CONV_CYCLES = 16;

    // ------------------------------------------------------------
    // trigger select codes
    // ------------------------------------------------------------
    localparam logic [1:0] TRIG_SOFT   = 2'h0;
    localparam logic [1:0] TRIG_TIMER3 = 2'h1;
    localparam logic [1:0] TRIG_STROBE = 2'h2;
    localparam logic [1:0] TRIG_TIMER2 = 2'h3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic       RST_BIT  = 1'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // software write to the control byte
    typedef struct packed {
        logic       busyWrite;   // strobe: write of the busy bit
        logic       busyData;
        logic       windowWrite; // strobe: write of the window flag
        logic       windowData;
        logic       doneClear;   // strobe: clear completion flag
    } acsc_sw_write_type;

    // result byte pair
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } acsc_result_type;

endpackage

/* design/acsc_strobe_sync.sv */
// Purpose: synchronise the external strobe pin and detect rising edges
// Assumes: pin is asynchronous to clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module acsc_strobe_sync
    import acsc_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // pin and edge
    input  wire logic pinIn,
    output logic      risePulse
);

    logic stage1_ff;
    logic stage2_ff;
    logic prev_ff;

    // ------------------------------------------------------------
    // two-flop synchroniser and edge history
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage1_ff <= RST_BIT;
            stage2_ff <= RST_BIT;
            prev_ff   <= RST_BIT;
        end else begin
            stage1_ff <= pinIn;
            stage2_ff <= stage1_ff;
            prev_ff   <= stage2_ff;
        end
    end

    // rising edge seen after sync
    assign risePulse = stage2_ff & ~prev_ff;

endmodule // acsc_strobe_sync

/* design/acsc_conv_ctrl.sv */
// Purpose: start selection, busy tracking and result formatting
// Assumes: analog core reports result with a done pulse
// Notes:   window compare logic outside supplies a match pulse
`timescale 1ns/1ps

module acsc_conv_ctrl
    import acsc_pkg::*;
#(
    parameter int unsigned RES_W = RESULT_W
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset,
    // software access
    input  wire acsc_pkg::acsc_sw_write_type swWrite,
    input  wire logic [1:0]               triggerSelect,
    input  wire logic                     justifySelect,
    input  wire logic                     irqEnable,
    // trigger sources
    input  wire logic                     timer3Overflow,
    input  wire logic                     timer2Overflow,
    input  wire logic                     externalConvertStrobe,
    // analog core
    input  wire logic                     coreDone,
    input  wire logic [RES_W-1:0]         coreResult,
    input  wire logic                     windowMatch,
    output logic                          coreStart,
    // status
    output logic [7:0]                    controlRead,
    output logic                          conversionBusyFlag,
    output logic                          windowMatchFlag,
    output logic                          completeFlag,
    output logic                          completeIrq,
    output acsc_pkg::acsc_result_type     result
);
    import acsc_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_CONV = 2'h2
    } acsc_state_type;

    acsc_state_type  state_ff;
    acsc_state_type  nxt_state;
    logic            busy_ff;
    logic            window_ff;
    logic            done_ff;
    logic            irq_ff;
    logic            start_ff;
    acsc_result_type result_ff;
    acsc_result_type nxt_result;
    logic            strobeRise;
    logic            startReq;

    // strobe pin synchroniser
    acsc_strobe_sync u_sync (
        .clk       (clk),
        .reset     (reset),
        .pinIn     (externalConvertStrobe),
        .risePulse (strobeRise)
    );

    // ------------------------------------------------------------
    // start source selection
    // ------------------------------------------------------------
    // a start while busy is dropped; core cannot restart mid-way
    always_comb begin
        case (triggerSelect)
            TRIG_SOFT:   startReq = swWrite.busyWrite
                                    & swWrite.busyData;
            TRIG_TIMER3: startReq = timer3Overflow;
            TRIG_STROBE: startReq = strobeRise;
            TRIG_TIMER2: startReq = timer2Overflow;
            default:     startReq = 1'h0;
        endcase
    end

    // ------------------------------------------------------------
    // conversion state machine
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (startReq) begin
                    nxt_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (coreDone) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // busy follows the machine; zero from reset until a start
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_ff  <= RST_BIT;
            start_ff <= RST_BIT;
        end else begin
            busy_ff  <= (nxt_state == ST_CONV);
            start_ff <= (state_ff == ST_IDLE) & startReq;
        end
    end

    // ------------------------------------------------------------
    // interrupt on busy falling edge
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_ff <= RST_BIT;
        end else begin
            irq_ff <= busy_ff & (nxt_state != ST_CONV)
                      & irqEnable;
        end
    end

    // ------------------------------------------------------------
    // sticky flags: hardware set beats software clear
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            done_ff <= RST_BIT;
        end else if (state_ff == ST_CONV && coreDone) begin
            done_ff <= 1'h1;
        end else if (swWrite.doneClear) begin
            done_ff <= 1'h0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            window_ff <= RST_BIT;
        end else if (windowMatch) begin
            window_ff <= 1'h1;
        end else if (swWrite.windowWrite && !swWrite.windowData) begin
            window_ff <= 1'h0;
        end
    end

    // ------------------------------------------------------------
    // result justification
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] wide;
        wide = 16'h0000;
        if (justifySelect) begin
            wide[15 -: RES_W] = coreResult;
        end else begin
            wide[RES_W-1:0] = coreResult;
        end
        nxt_result.high = wide[15:8];
        nxt_result.low  = wide[7:0];
    end

    // result captured on done, which also ends busy
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            result_ff <= {RST_BYTE, RST_BYTE};
        end else if (state_ff == ST_CONV && coreDone) begin
            result_ff <= nxt_result;
        end
    end

    // ------------------------------------------------------------
    // control readback register
    // ------------------------------------------------------------
    // readback tracks the flag's next value, so a clear shows at once
    logic nxt_window;
    assign nxt_window = windowMatch
                        | (window_ff & ~(swWrite.windowWrite
                                         & ~swWrite.windowData));

    logic [7:0] ctrl_ff;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_ff <= RST_BYTE;
        end else begin
            ctrl_ff <= RST_BYTE;
            ctrl_ff[BUSY_BIT]           <= (nxt_state == ST_CONV);
            ctrl_ff[TRIG_MSB:TRIG_LSB]  <= triggerSelect;
            ctrl_ff[WINDOW_BIT]         <= nxt_window;
            ctrl_ff[JUSTIFY_BIT]        <= justifySelect;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign controlRead        = ctrl_ff;
    assign conversionBusyFlag = busy_ff;
    assign windowMatchFlag    = window_ff;
    assign completeFlag       = done_ff;
    assign completeIrq        = irq_ff;
    assign coreStart          = start_ff;
    assign result             = result_ff;

endmodule // acsc_conv_ctrl

/* test/acsc_conv_ctrl_checker.sv */
// Purpose: port-level assertions for the conversion start control
// Assumes: one clock domain, reset asynchronous and active high
// Notes:   bound onto every acsc_conv_ctrl instance
`timescale 1ns/1ps
module acsc_conv_ctrl_checker
    import acsc_pkg::*;
#(
    parameter int unsigned RES_W = RESULT_W
) (
    // clock and reset
    input wire logic                          clk,
    input wire logic                          reset,
    // inputs seen
    input wire acsc_pkg::acsc_sw_write_type   swWrite,
    input wire logic [1:0]                    triggerSelect,
    input wire logic                          justifySelect,
    input wire logic                          irqEnable,
    input wire logic                          timer3Overflow,
    input wire logic                          timer2Overflow,
    input wire logic                          externalConvertStrobe,
    input wire logic                          coreDone,
    input wire logic [RES_W-1:0]              coreResult,
    input wire logic                          windowMatch,
    // outputs seen
    input wire logic                          coreStart,
    input wire logic [7:0]                    controlRead,
    input wire logic                          conversionBusyFlag,
    input wire logic                          windowMatchFlag,
    input wire logic                          completeFlag,
    input wire logic                          completeIrq,
    input wire acsc_pkg::acsc_result_type     result
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // start, busy and completion
    // ------------------------------------------------------------
    a_soft_start: assert property (swWrite.busyWrite && swWrite.busyData
        && triggerSelect == TRIG_SOFT && !conversionBusyFlag
        |=> conversionBusyFlag && coreStart) else $error("soft start lost");
    a_timer3_start: assert property (timer3Overflow
        && triggerSelect == TRIG_TIMER3 && !conversionBusyFlag
        |=> conversionBusyFlag && coreStart) else $error("timer3 start lost");
    a_timer2_start: assert property (timer2Overflow
        && triggerSelect == TRIG_TIMER2 && !conversionBusyFlag
        |=> conversionBusyFlag && coreStart) else $error("timer2 start lost");
    a_strobe_start: assert property ($rose(externalConvertStrobe)
        && triggerSelect == TRIG_STROBE && !conversionBusyFlag
        |-> ##[1:6] conversionBusyFlag) else $error("strobe start lost");
    a_busy_hold: assert property (conversionBusyFlag && !coreDone
        |=> conversionBusyFlag) else $error("busy dropped early");
    a_done_clear: assert property (conversionBusyFlag && coreDone
        |=> !conversionBusyFlag && completeFlag) else $error("done wrong");
    a_irq_fall: assert property (completeIrq ==
        ($fell(conversionBusyFlag) && $past(irqEnable))) else $error("irq");
    a_result_fmt: assert property (conversionBusyFlag && coreDone
        |=> result == ($past(justifySelect)
        ? 16'($past(coreResult)) << (16 - RES_W) : 16'($past(coreResult))))
        else $error("result format wrong");
    // ------------------------------------------------------------
    // window flag and readback
    // ------------------------------------------------------------
    a_window_set: assert property (windowMatch |=> windowMatchFlag)
        else $error("window flag not set");
    a_window_keep: assert property (windowMatchFlag
        && !(swWrite.windowWrite && !swWrite.windowData)
        |=> windowMatchFlag) else $error("window flag lost");
    a_busy_bit: assert property (controlRead[BUSY_BIT]
        == conversionBusyFlag) else $error("busy readback wrong");
    c_irq: cover property (completeIrq);
    c_strobe: cover property ($rose(externalConvertStrobe) ##3 coreStart);
    c_window: cover property ($rose(windowMatchFlag));
endmodule // acsc_conv_ctrl_checker

bind acsc_conv_ctrl acsc_conv_ctrl_checker #(.RES_W(RES_W)) u_chk (.clk,
    .reset, .swWrite, .triggerSelect, .justifySelect, .irqEnable,
    .timer3Overflow, .timer2Overflow, .externalConvertStrobe, .coreDone,
    .coreResult, .windowMatch, .coreStart, .controlRead, .conversionBusyFlag,
    .windowMatchFlag, .completeFlag, .completeIrq, .result);

/* test/tb_top.sv */
// Purpose: directed self-checking bench for the conversion start control
// Assumes: inputs change on the falling edge of clk
// Notes:   the bench plays software, timers, pin and analog core
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
    import acsc_pkg::*;
    logic clk, reset, justifySelect, irqEnable, timer3Overflow;
    logic timer2Overflow, externalConvertStrobe, coreDone, windowMatch;
    logic coreStart, busy, windowMatchFlag, completeFlag, completeIrq;
    logic [1:0]        triggerSelect;
    logic [9:0]        coreResult;
    logic [7:0]        controlRead;
    acsc_sw_write_type swWrite;
    acsc_result_type   result;
    int                n_fail = 0;
    int                total_checks = 0;
    acsc_conv_ctrl u_acsc_conv_ctrl (.clk, .reset, .swWrite, .triggerSelect,
        .justifySelect, .irqEnable, .timer3Overflow, .timer2Overflow,
        .externalConvertStrobe, .coreDone, .coreResult, .windowMatch,
        .coreStart, .controlRead, .conversionBusyFlag(busy), .windowMatchFlag,
        .completeFlag, .completeIrq, .result);
    // 20 MHz clock
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    task automatic cyc(int n = 1);
        repeat (n) @(negedge clk);
    endtask
    // one-cycle software write of the busy bit
    task automatic sw_busy(logic d);
        swWrite.busyWrite = 1;
        swWrite.busyData = d;
        cyc();
        swWrite = '0;
    endtask
    // core ends the conversion; completion then cleared by software
    task automatic done_conv(logic [9:0] r, logic j, logic ie);
        justifySelect = j;
        irqEnable = ie;
        coreResult = r;
        cyc();
        coreDone = 1;
        cyc();
        coreDone = 0;
        `CHK("busy", 1'h0, busy)
        `CHK("complete", 1'h1, completeFlag)
        `CHK("irq", ie, completeIrq)
        `CHK("result", j ? {r, 6'h00} : {6'h00, r}, result)
        `CHK("justify bit", j, controlRead[JUSTIFY_BIT])
        cyc();
        `CHK("irq pulse", 1'h0, completeIrq)
        swWrite.doneClear = 1;
        cyc();
        swWrite = '0;
        `CHK("complete clr", 1'h0, completeFlag)
    endtask
    task automatic t_soft;
        triggerSelect = TRIG_SOFT;
        sw_busy(0);
        cyc(2);
        `CHK("write 0", 1'h0, busy)
        sw_busy(1);
        `CHK("busy", 1'h1, busy)
        `CHK("start", 1'h1, coreStart)
        `CHK("bit4", 1'h1, controlRead[BUSY_BIT])
        cyc(3);
        sw_busy(1);
        `CHK("no restart", 1'h0, coreStart)
        done_conv(10'h2A5, 0, 1);
    endtask
    // wrong sources first, then the selected timer
    task automatic t_timer(logic [1:0] sel);
        triggerSelect = sel;
        sw_busy(1);
        timer2Overflow = (sel == TRIG_TIMER3);
        timer3Overflow = (sel == TRIG_TIMER2);
        cyc();
        {timer2Overflow, timer3Overflow} = 2'h0;
        cyc();
        `CHK("wrong src", 1'h0, busy)
        timer3Overflow = (sel == TRIG_TIMER3);
        timer2Overflow = (sel == TRIG_TIMER2);
        cyc();
        {timer2Overflow, timer3Overflow} = 2'h0;
        `CHK("timer start", 1'h1, busy)
        done_conv(10'h3C1, 1, 0);
    endtask
    task automatic t_strobe;
        triggerSelect = TRIG_STROBE;
        externalConvertStrobe = 1;
        cyc(2);
        `CHK("strobe early", 1'h0, busy)
        cyc();
        `CHK("strobe start", 1'h1, busy)
        `CHK("sel rb", TRIG_STROBE, controlRead[TRIG_MSB:TRIG_LSB])
        done_conv(10'h155, 1, 1);
        cyc(6);
        `CHK("level no start", 1'h0, busy)
        externalConvertStrobe = 0;
    endtask
    task automatic t_window;
        windowMatch = 1;
        cyc();
        windowMatch = 0;
        `CHK("win set", 1'h1, windowMatchFlag)
        `CHK("win bit", 1'h1, controlRead[WINDOW_BIT])
        swWrite.windowWrite = 1;
        swWrite.windowData = 1;
        cyc();
        swWrite = '0;
        cyc(5);
        `CHK("win kept", 1'h1, windowMatchFlag)
        swWrite.windowWrite = 1;
        cyc();
        swWrite = '0;
        `CHK("win clr", 1'h0, windowMatchFlag)
        `CHK("win bit clr", 1'h0, controlRead[WINDOW_BIT])
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // watchdog, about 37 times the expected run
    initial begin
        #100000;
        n_fail++;
        finish_test();
    end
    initial begin
        {reset, triggerSelect, justifySelect, irqEnable} = '1;
        {timer3Overflow, timer2Overflow, externalConvertStrobe} = 3'h0;
        {coreDone, coreResult, windowMatch, swWrite} = '0;
        repeat (4) @(posedge clk);
        cyc();
        reset = 0;
        cyc();
        `CHK("rst busy", 1'h0, busy)
        `CHK("rst result", 16'h0000, result)
        t_soft();
        t_timer(TRIG_TIMER3);
        t_timer(TRIG_TIMER2);
        t_strobe();
        t_window();
        finish_test();
    end
endmodule // tb_top
